// ==== logic/rx_path_routing_and_monitor_sequencer.sv ====
// Purpose: Receive input routing, observation roles, converter bypass and
//          the low-power monitor sleep/detect sequencer, behind an APB slave
// Assumes: rx_needed, tx_slot and rx_power come from logic on pclk
// Notes:   One access wait state on every APB transfer

module rx_path_routing_and_monitor_sequencer #(
    parameter logic [7:0] DEVICE_OBS_GAIN = 8'h10
) (
    input  wire logic                                   pclk,
    input  wire logic                                   presetn,
    input  wire logic                                   psel,
    input  wire logic                                   penable,
    input  wire logic                                   pwrite,
    input  wire logic [7:0]                             paddr,
    input  wire logic [31:0]                            pwdata,
    output logic      [31:0]                            prdata,
    output logic                                        pready,
    output logic                                        pslverr,
    input  wire logic [rx_route_pkg::NCH-1:0]           rx_needed,
    input  wire logic [rx_route_pkg::NCH-1:0]           tx_slot,
    input  wire logic [15:0]                            rx_power,
    output rx_route_pkg::rx_route_t [rx_route_pkg::NCH-1:0] route,
    output logic      [7:0]                             obs_gain,
    output logic                                        ddc_bypass,
    output rx_route_pkg::monitor_out_t                  monitor
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic in_range(input logic [31:0] f,
                                      input logic [31:0] lo,
                                      input logic [31:0] hi);
        return (f >= lo) && (f <= hi);
    endfunction : in_range

    // A zero duration still spends one cycle in the state
    function automatic logic [31:0] dur_last(input logic [31:0] d);
        return (d == 32'h0) ? 32'h0 : d - 32'h1;
    endfunction : dur_last

    rx_route_pkg::state_t s;
    rx_route_pkg::state_t n;

    logic                  acc;
    logic                  wr;
    logic                  rd;
    logic                  hit_map;
    logic                  main_b;
    logic                  clr_det;
    logic                  set_det;
    logic                  obs_ok;
    rx_route_pkg::loopback_t lb;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        n       = s;
        lb      = rx_route_pkg::LB_NONE;
        obs_ok  = 1'b0;
        clr_det = 1'b0;
        set_det = 1'b0;
        acc     = psel && penable && !s.pready;
        wr      = acc && pwrite;
        rd      = acc && !pwrite;
        n.pready  = acc;
        n.pslverr = 1'b0;
        n.mon_out.detect_pulse = 1'b0;

        hit_map = 1'b1;
        unique case (paddr)
            rx_route_pkg::OFF_CTRL, rx_route_pkg::OFF_OBS,
            rx_route_pkg::OFF_RANGE_A_LO, rx_route_pkg::OFF_RANGE_A_HI,
            rx_route_pkg::OFF_RANGE_B_LO, rx_route_pkg::OFF_RANGE_B_HI,
            rx_route_pkg::OFF_CARRIER, rx_route_pkg::OFF_SLEEP,
            rx_route_pkg::OFF_DETECT, rx_route_pkg::OFF_THRESH,
            rx_route_pkg::OFF_MON_LO, rx_route_pkg::OFF_MON_CTRL,
            rx_route_pkg::OFF_STATUS, rx_route_pkg::OFF_OBS_GAIN: hit_map = 1'b1;
            default: hit_map = 1'b0;
        endcase
        if (acc && !hit_map) begin
            n.pslverr = 1'b1;
        end

        // Register writes
        if (wr && hit_map) begin
            unique case (paddr)
                rx_route_pkg::OFF_CTRL: begin
                    // The main port is an initialization choice: frozen once locked
                    if (!s.locked) begin
                        n.main_port_b = pwdata[rx_route_pkg::CTRL_PORT_B];
                        n.locked      = pwdata[rx_route_pkg::CTRL_LOCK];
                    end
                    n.dyn_en  = pwdata[rx_route_pkg::CTRL_DYN];
                    n.if_mode = pwdata[rx_route_pkg::CTRL_IF_MODE];
                end
                rx_route_pkg::OFF_OBS: begin
                    for (int i = 0; i < rx_route_pkg::NCH; i++) begin
                        n.lb_sel[i] = rx_route_pkg::loopback_t'(
                            pwdata[rx_route_pkg::OBS_LB_LSB + 2*i +: 2]);
                    end
                    n.obs_req   = pwdata[rx_route_pkg::OBS_REQ_LSB +: rx_route_pkg::NCH];
                    n.host_owns = pwdata[rx_route_pkg::OBS_HOST];
                end
                rx_route_pkg::OFF_RANGE_A_LO: n.a_lo       = pwdata;
                rx_route_pkg::OFF_RANGE_A_HI: n.a_hi       = pwdata;
                rx_route_pkg::OFF_RANGE_B_LO: n.b_lo       = pwdata;
                rx_route_pkg::OFF_RANGE_B_HI: n.b_hi       = pwdata;
                rx_route_pkg::OFF_CARRIER:    n.carrier    = pwdata;
                rx_route_pkg::OFF_SLEEP:      n.sleep_len  = pwdata;
                rx_route_pkg::OFF_DETECT:     n.detect_len = pwdata;
                rx_route_pkg::OFF_THRESH:     n.thresh     = pwdata[15:0];
                rx_route_pkg::OFF_MON_LO:     n.mon_lo     = pwdata;
                rx_route_pkg::OFF_MON_CTRL:   n.mon_en     = pwdata[0];
                rx_route_pkg::OFF_STATUS:     clr_det      = pwdata[rx_route_pkg::STAT_DET];
                rx_route_pkg::OFF_OBS_GAIN:   n.obs_gain   = pwdata[7:0];
                default: n.pslverr = 1'b1;
            endcase
        end

        // Dynamic port choice, shared by both channels
        if (s.dyn_en) begin
            if (in_range(s.carrier, s.a_lo, s.a_hi)) begin
                n.dyn_port_b = 1'b0;
            end else if (in_range(s.carrier, s.b_lo, s.b_hi)) begin
                n.dyn_port_b = 1'b1;
            end
            // Outside both ranges the port stays as it was
        end

        // Monitor sequencer
        unique case (s.mon)
            rx_route_pkg::MON_IDLE: begin
                if (s.mon_en) begin
                    n.mon = rx_route_pkg::MON_SLEEP;
                    n.cnt = 32'h0;
                end
            end
            rx_route_pkg::MON_SLEEP: begin
                if (!s.mon_en) begin
                    n.mon = rx_route_pkg::MON_IDLE;
                end else if (s.cnt >= dur_last(s.sleep_len)) begin
                    n.mon = rx_route_pkg::MON_DETECT;
                    n.cnt = 32'h0;
                end else begin
                    n.cnt = s.cnt + 32'h1;
                end
            end
            rx_route_pkg::MON_DETECT: begin
                if (!s.mon_en) begin
                    n.mon = rx_route_pkg::MON_IDLE;
                end else if (rx_power >= s.thresh) begin
                    // Hardware clears the enable so normal reception resumes
                    n.mon    = rx_route_pkg::MON_IDLE;
                    n.mon_en = 1'b0;
                    set_det  = 1'b1;
                end else if (s.cnt >= dur_last(s.detect_len)) begin
                    n.mon = rx_route_pkg::MON_SLEEP;
                    n.cnt = 32'h0;
                end else begin
                    n.cnt = s.cnt + 32'h1;
                end
            end
            default: begin
                n.mon    = rx_route_pkg::MON_IDLE;
                n.mon_en = 1'b0;
            end
        endcase

        // Set wins over a software clear in the same cycle
        if (clr_det) begin
            n.detected = 1'b0;
        end
        if (set_det) begin
            n.detected = 1'b1;
        end
        n.mon_out.detect_pulse = set_det;
        n.mon_out.rx_enable    = (n.mon == rx_route_pkg::MON_DETECT);
        n.mon_out.low_power    = (n.mon == rx_route_pkg::MON_SLEEP);
        n.mon_out.lo_freq      = s.mon_lo;
        n.mon_out.threshold    = s.thresh;

        n.ddc_bypass = !s.if_mode;

        // Per-channel routing; channel i only ever sees transmitter i
        main_b = s.dyn_en ? n.dyn_port_b : s.main_port_b;
        for (int i = 0; i < rx_route_pkg::NCH; i++) begin
            obs_ok = s.obs_req[i] && !rx_needed[i]
                     && (s.host_owns || tx_slot[i])
                     && (s.mon == rx_route_pkg::MON_IDLE);
            lb = obs_ok ? s.lb_sel[i] : rx_route_pkg::LB_NONE;
            if (s.dyn_en && (lb == rx_route_pkg::LB_EXT_PRE
                             || lb == rx_route_pkg::LB_EXT_POST)) begin
                lb = rx_route_pkg::LB_NONE;
            end
            unique case (lb)
                rx_route_pkg::LB_INTERNAL:
                    n.route[i].input_sel = rx_route_pkg::RX_IN_INTERNAL;
                rx_route_pkg::LB_EXT_PRE, rx_route_pkg::LB_EXT_POST:
                    n.route[i].input_sel = main_b ? rx_route_pkg::RX_IN_PORT_A
                                                  : rx_route_pkg::RX_IN_PORT_B;
                default:
                    n.route[i].input_sel = main_b ? rx_route_pkg::RX_IN_PORT_B
                                                  : rx_route_pkg::RX_IN_PORT_A;
            endcase
            // A single two-bit code makes both external paths exclusive
            n.route[i].ext_loopback_pre_amp  = (lb == rx_route_pkg::LB_EXT_PRE);
            n.route[i].ext_loopback_post_amp = (lb == rx_route_pkg::LB_EXT_POST);
            n.route[i].observation_receiver  = (lb != rx_route_pkg::LB_NONE);
        end

        // Device-owned observation uses its own gain; registered so the pin never glitches
        n.gain_out = s.host_owns ? s.obs_gain : DEVICE_OBS_GAIN;

        // Read data
        if (rd) begin
            unique case (paddr)
                rx_route_pkg::OFF_CTRL:
                    n.prdata = {28'h0, s.if_mode, s.dyn_en, s.locked, s.main_port_b};
                rx_route_pkg::OFF_OBS:
                    n.prdata = {25'h0, s.host_owns, s.obs_req, s.lb_sel};
                rx_route_pkg::OFF_RANGE_A_LO: n.prdata = s.a_lo;
                rx_route_pkg::OFF_RANGE_A_HI: n.prdata = s.a_hi;
                rx_route_pkg::OFF_RANGE_B_LO: n.prdata = s.b_lo;
                rx_route_pkg::OFF_RANGE_B_HI: n.prdata = s.b_hi;
                rx_route_pkg::OFF_CARRIER:    n.prdata = s.carrier;
                rx_route_pkg::OFF_SLEEP:      n.prdata = s.sleep_len;
                rx_route_pkg::OFF_DETECT:     n.prdata = s.detect_len;
                rx_route_pkg::OFF_THRESH:     n.prdata = {16'h0, s.thresh};
                rx_route_pkg::OFF_MON_LO:     n.prdata = s.mon_lo;
                rx_route_pkg::OFF_MON_CTRL:   n.prdata = {31'h0, s.mon_en};
                rx_route_pkg::OFF_STATUS:
                    n.prdata = {27'h0, s.mon, s.dyn_port_b, s.detected};
                rx_route_pkg::OFF_OBS_GAIN:   n.prdata = {24'h0, s.obs_gain};
                default:                      n.prdata = 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s            <= '0;
            s.sleep_len  <= rx_route_pkg::RST_SLEEP;
            s.detect_len <= rx_route_pkg::RST_DETECT;
            s.thresh     <= rx_route_pkg::RST_THRESH;
            s.obs_gain   <= rx_route_pkg::RST_GAIN;
            s.mon        <= rx_route_pkg::MON_IDLE;
            s.ddc_bypass <= 1'b1;
            s.gain_out   <= DEVICE_OBS_GAIN;
            s.route      <= {rx_route_pkg::NCH{rx_route_pkg::rx_route_t'(
                              {rx_route_pkg::RX_IN_PORT_A, 3'b000})}};
        end else begin
            s <= n;
        end
    end

    assign prdata     = s.prdata;
    assign pready     = s.pready;
    assign pslverr    = s.pslverr;
    assign route      = s.route;
    assign obs_gain   = s.gain_out;
    assign ddc_bypass = s.ddc_bypass;
    assign monitor    = s.mon_out;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence sleep_done;
        s.mon == rx_route_pkg::MON_SLEEP && s.mon_en
            && s.cnt >= dur_last(s.sleep_len);
    endsequence
    sequence detect_start;
        s.mon == rx_route_pkg::MON_DETECT && s.cnt == 32'h0 && monitor.rx_enable;
    endsequence
    sequence power_hit;
        s.mon == rx_route_pkg::MON_DETECT && s.mon_en && rx_power >= s.thresh;
    endsequence
    sequence detect_miss;
        s.mon == rx_route_pkg::MON_DETECT && s.mon_en && rx_power < s.thresh
            && s.cnt >= dur_last(s.detect_len);
    endsequence

    sleep_to_detect_a: assert property (sleep_done |=> detect_start)
        else $error("sleep did not hand over to detect");
    detect_exit_a: assert property (power_hit |=>
        s.mon == rx_route_pkg::MON_IDLE && !s.mon_en && monitor.detect_pulse
        ##1 !monitor.detect_pulse)
        else $error("detection did not end the monitor cycle");
    detect_flag_a: assert property (power_hit |=> s.detected
        ##1 (s.detected || $past(clr_det)))
        else $error("detection flag not held");
    miss_resleep_a: assert property (detect_miss |=>
        s.mon == rx_route_pkg::MON_SLEEP && monitor.low_power)
        else $error("missed detect did not re-enter sleep");
    cycle_stays_a: assert property (s.mon_en && s.mon != rx_route_pkg::MON_IDLE
        && !(s.mon == rx_route_pkg::MON_DETECT && rx_power >= s.thresh) && !wr
        |=> s.mon != rx_route_pkg::MON_IDLE)
        else $error("monitor left its cycle without a detection");
    detect_rx_a: assert property (s.mon == rx_route_pkg::MON_DETECT
        |-> monitor.rx_enable && monitor.lo_freq == $past(s.mon_lo))
        else $error("detect state without receiver enabled");
    ext_excl_a: assert property (!(route[0].ext_loopback_pre_amp
        && route[0].ext_loopback_post_amp) && !(route[1].ext_loopback_pre_amp
        && route[1].ext_loopback_post_amp))
        else $error("both external loopbacks enabled");
    dyn_no_ext_a: assert property ($past(s.dyn_en) |->
        !(route[0].ext_loopback_pre_amp || route[0].ext_loopback_post_amp
          || route[1].ext_loopback_pre_amp || route[1].ext_loopback_post_amp))
        else $error("external loopback while dynamic switching");
    obs_idle_rx_a: assert property (route[0].observation_receiver
        |-> !$past(rx_needed[0]))
        else $error("observation while reception needed");
    tracking_slot_a: assert property (route[1].observation_receiver
        && !$past(s.host_owns) |-> $past(tx_slot[1]))
        else $error("device observation outside transmit slot");
    same_port_a: assert property (s.dyn_en && !route[0].observation_receiver
        && !route[1].observation_receiver |-> route[0].input_sel == route[1].input_sel)
        else $error("channels on different ports while switching");
    keep_port_a: assert property (s.dyn_en && !in_range(s.carrier, s.a_lo, s.a_hi)
        && !in_range(s.carrier, s.b_lo, s.b_hi) |=> $stable(s.dyn_port_b))
        else $error("port changed with carrier outside both ranges");
    port_lock_a: assert property (s.locked |=> $stable(s.main_port_b))
        else $error("main port changed after lock");
    ddc_mode_a: assert property (ddc_bypass == !$past(s.if_mode))
        else $error("converter bypass wrong for the mode");

endmodule : rx_path_routing_and_monitor_sequencer

// ==== logic/rx_route_pkg.sv ====
// Purpose: Shared constants and types for the receive path routing block
// Assumes: APB with 32-bit data, one word per register
// Notes:   Two receive channels, each with ports A, B and an internal input
package rx_route_pkg;

    localparam int unsigned NCH = 2;

    localparam logic [7:0] OFF_CTRL       = 8'h00;
    localparam logic [7:0] OFF_OBS        = 8'h04;
    localparam logic [7:0] OFF_RANGE_A_LO = 8'h08;
    localparam logic [7:0] OFF_RANGE_A_HI = 8'h0c;
    localparam logic [7:0] OFF_RANGE_B_LO = 8'h10;
    localparam logic [7:0] OFF_RANGE_B_HI = 8'h14;
    localparam logic [7:0] OFF_CARRIER    = 8'h18;
    localparam logic [7:0] OFF_SLEEP      = 8'h1c;
    localparam logic [7:0] OFF_DETECT     = 8'h20;
    localparam logic [7:0] OFF_THRESH     = 8'h24;
    localparam logic [7:0] OFF_MON_LO     = 8'h28;
    localparam logic [7:0] OFF_MON_CTRL   = 8'h2c;
    localparam logic [7:0] OFF_STATUS     = 8'h30;
    localparam logic [7:0] OFF_OBS_GAIN   = 8'h34;

    // Field positions
    localparam int unsigned CTRL_PORT_B  = 0;
    localparam int unsigned CTRL_LOCK    = 1;
    localparam int unsigned CTRL_DYN     = 2;
    localparam int unsigned CTRL_IF_MODE = 3;
    localparam int unsigned OBS_LB_LSB   = 0;
    localparam int unsigned OBS_REQ_LSB  = 4;
    localparam int unsigned OBS_HOST     = 6;
    localparam int unsigned STAT_DET     = 0;

    // Values after reset
    localparam logic [31:0] RST_SLEEP  = 32'h0000_0064;
    localparam logic [31:0] RST_DETECT = 32'h0000_000a;
    localparam logic [15:0] RST_THRESH = 16'h0100;
    localparam logic [7:0]  RST_GAIN   = 8'h00;

    typedef enum logic [1:0] {
        LB_NONE     = 2'h0,
        LB_INTERNAL = 2'h1,
        LB_EXT_PRE  = 2'h2,
        LB_EXT_POST = 2'h3
    } loopback_t;

    typedef enum logic [2:0] {
        RX_IN_PORT_A   = 3'b001,
        RX_IN_PORT_B   = 3'b010,
        RX_IN_INTERNAL = 3'b100
    } rx_input_t;

    typedef enum logic [2:0] {
        MON_IDLE   = 3'b001,
        MON_SLEEP  = 3'b010,
        MON_DETECT = 3'b100
    } mon_state_t;

    typedef struct packed {
        rx_input_t input_sel;
        logic      ext_loopback_pre_amp;
        logic      ext_loopback_post_amp;
        logic      observation_receiver;
    } rx_route_t;

    typedef struct packed {
        logic        rx_enable;
        logic        low_power;
        logic        detect_pulse;
        logic [31:0] lo_freq;
        logic [15:0] threshold;
    } monitor_out_t;

    typedef struct packed {
        logic                 main_port_b;
        logic                 locked;
        logic                 dyn_en;
        logic                 if_mode;
        loopback_t [NCH-1:0]  lb_sel;
        logic [NCH-1:0]       obs_req;
        logic                 host_owns;
        logic [31:0]          a_lo;
        logic [31:0]          a_hi;
        logic [31:0]          b_lo;
        logic [31:0]          b_hi;
        logic [31:0]          carrier;
        logic [31:0]          sleep_len;
        logic [31:0]          detect_len;
        logic [31:0]          mon_lo;
        logic [15:0]          thresh;
        logic [7:0]           obs_gain;
        logic                 mon_en;
        logic                 detected;
        mon_state_t           mon;
        logic [31:0]          cnt;
        logic                 dyn_port_b;
        rx_route_t [NCH-1:0]  route;
        monitor_out_t         mon_out;
        logic                 ddc_bypass;
        logic [7:0]           gain_out;
        logic [31:0]          prdata;
        logic                 pready;
        logic                 pslverr;
    } state_t;

endpackage : rx_route_pkg

// ==== verification/rf_side_model.sv ====
// Purpose: Far side: reception demand, transmit slots and signal power
// Assumes: The bench sets the wanted levels
// Notes:   One cycle of latency, as a registered front end adds
module rf_side_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [1:0]  want_rx,
    input  wire logic [1:0]  want_slot,
    input  wire logic [15:0] want_power,
    output logic      [1:0]  rx_needed,
    output logic      [1:0]  tx_slot,
    output logic      [15:0] rx_power
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_needed <= 2'h3;
            tx_slot   <= 2'h0;
            rx_power  <= 16'h0000;
        end else begin
            rx_needed <= want_rx;
            tx_slot   <= want_slot;
            rx_power  <= want_power;
        end
    end
endmodule : rf_side_model

// ==== verification/tb_rx_path_routing_and_monitor_sequencer.sv ====
// Purpose: Self-checking bench for receive routing and monitor sequencing
// Assumes: One access wait state; sleep and detect lengths kept small
// Notes:   Ranges are programmed disjoint, as software must
module tb_rx_path_routing_and_monitor_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, ddc_bypass;
    logic [7:0] paddr = 8'h00, obs_gain;
    logic [31:0] pwdata = 32'h0, prdata, r, v;
    logic [1:0] want_rx = 2'h3, want_slot = 2'h0, rx_needed, tx_slot;
    logic [15:0] want_power = 16'h0000, rx_power, th;
    logic e, lp, en, o;
    rx_route_pkg::rx_route_t [rx_route_pkg::NCH-1:0] route;
    rx_route_pkg::monitor_out_t monitor;
    int error_cnt = 0, n_compared = 0, cyc = 0, seed = 21586;
    always #5 pclk = ~pclk;
    rf_side_model u_rf_side_model (.pclk(pclk), .presetn(presetn), .want_rx(want_rx),
        .want_slot(want_slot), .want_power(want_power), .rx_needed(rx_needed),
        .tx_slot(tx_slot), .rx_power(rx_power));
    rx_path_routing_and_monitor_sequencer u_rx_path_routing_and_monitor_sequencer (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_needed(rx_needed), .tx_slot(tx_slot), .rx_power(rx_power), .route(route),
        .obs_gain(obs_gain), .ddc_bypass(ddc_bypass), .monitor(monitor));
    task print_verdict;
        if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1, a, d);
        repeat (3) @(posedge pclk);
    endtask : wr
    function automatic logic obs_exp(input logic q, input logic nd, input logic sl, input logic h);
        return q & ~nd & (h | sl);
    endfunction : obs_exp
    always @(posedge pclk) if (++cyc == 20000) begin
        error_cnt++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        chk(route[0].input_sel, rx_route_pkg::RX_IN_PORT_A);
        chk({ddc_bypass, obs_gain}, 9'h110);
        apb(0, 8'h80, 32'h0); chk(e, 1);
        wr(rx_route_pkg::OFF_CTRL, 32'h3);
        wr(rx_route_pkg::OFF_CTRL, 32'h8);
        chk({route[0].input_sel, route[1].input_sel}, 6'h12);
        chk(ddc_bypass, 0);
        for (int i = 0; i < 12; i++) begin
            v = $random(seed);
            want_rx <= v[1:0]; want_slot <= v[3:2];
            wr(rx_route_pkg::OFF_OBS_GAIN, v[15:8]);
            wr(rx_route_pkg::OFF_OBS, {v[6:4], 4'h5});
            for (int c = 0; c < 2; c++) begin
                o = obs_exp(v[4+c], v[c], v[2+c], v[6]);
                chk(route[c].observation_receiver, o);
                chk(route[c].input_sel, o ? 3'h4 : 3'h2);
            end
            chk(obs_gain, v[6] ? v[15:8] : 8'h10);
        end
        want_rx <= 2'h0;
        wr(rx_route_pkg::OFF_OBS, 32'h7e);
        chk({route[0][2:1], route[1][2:1]}, 4'h9);
        wr(rx_route_pkg::OFF_RANGE_A_LO, 100); wr(rx_route_pkg::OFF_RANGE_A_HI, 200);
        wr(rx_route_pkg::OFF_RANGE_B_LO, 300); wr(rx_route_pkg::OFF_RANGE_B_HI, 400);
        wr(rx_route_pkg::OFF_CARRIER, 150); wr(rx_route_pkg::OFF_CTRL, 32'hc);
        foreach (route[c]) chk({route[c].input_sel, route[c][2:1]}, 5'h04);
        wr(rx_route_pkg::OFF_CARRIER, 250); chk(route[1].input_sel, 3'h1);
        wr(rx_route_pkg::OFF_CARRIER, 400); chk(route[1].input_sel, 3'h2);
        th = $random(seed) | 16'h0100;
        want_power <= th - 1;
        wr(rx_route_pkg::OFF_SLEEP, 2); wr(rx_route_pkg::OFF_DETECT, 1);
        wr(rx_route_pkg::OFF_THRESH, th); wr(rx_route_pkg::OFF_MON_LO, 32'h5a5a);
        wr(rx_route_pkg::OFF_MON_CTRL, 1);
        lp = 0; en = 0;
        repeat (12) @(posedge pclk) begin
            lp |= monitor.low_power;
            en |= monitor.rx_enable;
        end
        chk({lp, en, monitor.detect_pulse, monitor.threshold}, {3'h6, th});
        chk(monitor.lo_freq, 32'h5a5a);
        want_power <= th;
        for (int k = 0; k < 20 && monitor.detect_pulse !== 1'b1; k++) @(posedge pclk);
        chk(monitor.detect_pulse, 1);
        repeat (2) @(posedge pclk);
        chk({monitor.low_power, monitor.rx_enable}, 0);
        apb(0, rx_route_pkg::OFF_STATUS, 0); chk(r[0], 1);
        apb(0, rx_route_pkg::OFF_MON_CTRL, 0); chk(r[0], 0);
        wr(rx_route_pkg::OFF_STATUS, 1);
        apb(0, rx_route_pkg::OFF_STATUS, 0); chk(r[0], 0);
        print_verdict();
    end
endmodule : tb_rx_path_routing_and_monitor_sequencer
